// file: acrt_params.svh
// constants of the channel result and threshold block
`ifndef ACRT_PARAMS_SVH
`define ACRT_PARAMS_SVH

// channel count and result width
`define ACRT_NCH          12
`define ACRT_RES_W        12
`define ACRT_CHN_W        4

// register map, byte addresses
`define ACRT_CHAN_BASE    32'h4001c020
`define ACRT_STAT_ADDR    32'h4001c100
`define ACRT_MASK_ADDR    32'h4001c104

// channel word fields
`define ACRT_RESULT_LSB   4
`define ACRT_RANGE_LSB    16
`define ACRT_CROSS_LSB    18
`define ACRT_CHAN_LSB     26
`define ACRT_OVR_BIT      30
`define ACRT_DONE_BIT     31

// status and mask fields
`define ACRT_STAT_W       25
`define ACRT_STAT_CMP_LSB 12
`define ACRT_STAT_OVR_BIT 24
`define ACRT_STAT_RST     25'h0000000
`define ACRT_MASK_RST     25'h0000000

// compare codes
`define ACRT_RANGE_IN     2'h0
`define ACRT_RANGE_BELOW  2'h1
`define ACRT_RANGE_ABOVE  2'h2
`define ACRT_CROSS_NONE   2'h0
`define ACRT_CROSS_DOWN   2'h2
`define ACRT_CROSS_UP     2'h3

`endif

// file: acrt_pkg.sv
// types of the channel result and threshold block
`include "acrt_params.svh"

package acrt_pkg;

    typedef struct packed {
        logic [`ACRT_RES_W-1:0] low;
        logic [`ACRT_RES_W-1:0] high;
    } acrt_thr_type;

    typedef struct packed {
        logic                   valid;
        logic [`ACRT_CHN_W-1:0] chan;
        logic [`ACRT_RES_W-1:0] result;
    } acrt_conv_type;

    typedef struct packed {
        logic                   valid;
        logic [`ACRT_CHN_W-1:0] chan;
    } acrt_gread_type;

    typedef struct packed {
        logic                   done;
        logic                   ovr;
        logic                   seen;
        logic [1:0]             crs;
        logic [1:0]             rng;
        logic [`ACRT_RES_W-1:0] result;
    } acrt_chan_type;

endpackage

// file: acrt_chan.sv
// one channel: result, compare codes and flags
`timescale 1ns/1ps
`include "acrt_params.svh"

module acrt_chan (
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   arst_n_in,
    // conversion and compare
    input  wire logic                   load_in,
    input  wire logic [`ACRT_RES_W-1:0] result_in,
    input  acrt_pkg::acrt_thr_type      thr_in,
    input  wire logic                   clr_in,
    // channel state
    output acrt_pkg::acrt_chan_type     state_out,
    output logic                        cmp_evt_out,
    output logic                        ovr_evt_out
);
    import acrt_pkg::*;

    logic [`ACRT_RES_W-1:0] result_r;
    logic [1:0]             rng_r;
    logic [1:0]             crs_r;
    logic                   seen_r;
    logic                   done_r;
    logic                   ovr_r;
    logic [1:0]             rng_nxt;
    logic [1:0]             crs_nxt;
    logic                   below_now;
    logic                   below_prev;

    // equal to the low threshold counts as above for crossing
    always_comb begin
        below_now  = result_in < thr_in.low;
        below_prev = result_r < thr_in.low;
        if (below_now) begin
            rng_nxt = `ACRT_RANGE_BELOW;
        end else if (result_in > thr_in.high) begin
            rng_nxt = `ACRT_RANGE_ABOVE;
        end else begin
            rng_nxt = `ACRT_RANGE_IN;
        end
        // no previous sample after reset, so no crossing on the first
        if (!seen_r || (below_now == below_prev)) begin
            crs_nxt = `ACRT_CROSS_NONE;
        end else if (below_now) begin
            crs_nxt = `ACRT_CROSS_DOWN;
        end else begin
            crs_nxt = `ACRT_CROSS_UP;
        end
    end

    // result and both codes move in one edge
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result_r <= '0;
            rng_r    <= `ACRT_RANGE_IN;
            crs_r    <= `ACRT_CROSS_NONE;
            seen_r   <= 1'b0;
        end else if (load_in) begin
            result_r <= result_in;
            rng_r    <= rng_nxt;
            crs_r    <= crs_nxt;
            seen_r   <= 1'b1;
        end
    end

    // a new result wins over a read in the same cycle
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            done_r <= 1'b0;
        end else if (load_in) begin
            done_r <= 1'b1;
        end else if (clr_in) begin
            done_r <= 1'b0;
        end
    end

    // a result read in the same cycle is not overwritten unread
    assign ovr_evt_out = load_in && done_r && !clr_in;

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ovr_r <= 1'b0;
        end else if (ovr_evt_out) begin
            ovr_r <= 1'b1;
        end else if (clr_in) begin
            ovr_r <= 1'b0;
        end
    end

    assign cmp_evt_out = load_in &&
                         ((rng_nxt != `ACRT_RANGE_IN) || (crs_nxt != `ACRT_CROSS_NONE));

    assign state_out = '{done: done_r, ovr: ovr_r, seen: seen_r, crs: crs_r,
                         rng: rng_r, result: result_r};

endmodule // acrt_chan

// file: acrt_top.sv
// channel result registers with threshold compare, apb slave and interrupt
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "acrt_params.svh"

module acrt_top (
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   arst_n_in,
    // apb slave
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [31:0]            paddr_in,
    input  wire logic [31:0]            pwdata_in,
    output logic      [31:0]            prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    // converter side
    input  acrt_pkg::acrt_conv_type     conv_in,
    input  acrt_pkg::acrt_gread_type    gread_in,
    // thresholds and set select
    input  acrt_pkg::acrt_thr_type      thr0_in,
    input  acrt_pkg::acrt_thr_type      thr1_in,
    input  wire logic [`ACRT_NCH-1:0]   thr_sel_in,
    // flags and requests
    output logic      [`ACRT_NCH-1:0]   done_flags_out,
    output logic      [`ACRT_NCH-1:0]   ovr_flags_out,
    output logic                        overrun_req_out,
    output logic                        irq_out
);
    import acrt_pkg::*;

    localparam int NCH = `ACRT_NCH;

    acrt_chan_type           ch_st    [NCH];
    acrt_thr_type            sel_thr  [NCH];
    logic [31:0]             word     [NCH];
    logic [NCH-1:0]          load;
    logic [NCH-1:0]          clr;
    logic [NCH-1:0]          cmp_evt;
    logic [NCH-1:0]          ovr_evt;
    logic [NCH-1:0]          rd_clr;

    logic [31:0]             off;
    logic [3:0]              idx;
    logic                    chan_hit;
    logic                    stat_hit;
    logic                    mask_hit;
    logic                    setup;
    logic                    access;
    logic                    stat_clr;
    logic [31:0]             rd_word;
    logic                    rd_err;

    logic [31:0]             prdata_r;
    logic                    err_r;
    logic [`ACRT_STAT_W-1:0] stat_r;
    logic [`ACRT_STAT_W-1:0] stat_nxt;
    logic [`ACRT_STAT_W-1:0] mask_r;

    // address decode
    assign off      = paddr_in - `ACRT_CHAN_BASE;
    assign idx      = off[5:2];
    assign chan_hit = (off[1:0] == 2'h0) && (off[31:2] < 30'(NCH));
    assign stat_hit = paddr_in == `ACRT_STAT_ADDR;
    assign mask_hit = paddr_in == `ACRT_MASK_ADDR;
    assign setup    = psel_in && !penable_in;
    assign access   = psel_in && penable_in;
    assign stat_clr = setup && !pwrite_in && stat_hit;

    // per channel state and word
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            assign sel_thr[g] = thr_sel_in[g] ? thr1_in : thr0_in;
            assign load[g]    = conv_in.valid && (conv_in.chan == 4'(g));
            // clear is taken where the data is sampled so nothing slips between
            assign rd_clr[g]  = setup && !pwrite_in && chan_hit && (idx == 4'(g));
            assign clr[g]     = rd_clr[g] ||
                                (gread_in.valid && (gread_in.chan == 4'(g)));

            acrt_chan u_chan (
                .mclk_in     (mclk_in),
                .arst_n_in   (arst_n_in),
                .load_in     (load[g]),
                .result_in   (conv_in.result),
                .thr_in      (sel_thr[g]),
                .clr_in      (clr[g]),
                .state_out   (ch_st[g]),
                .cmp_evt_out (cmp_evt[g]),
                .ovr_evt_out (ovr_evt[g])
            );

            // reserved fields read as zero
            assign word[g] = {ch_st[g].done, ch_st[g].ovr, 4'(g), 6'h00,
                              ch_st[g].crs, ch_st[g].rng,
                              ch_st[g].result, 4'h0};

            assign done_flags_out[g] = ch_st[g].done;
            assign ovr_flags_out[g]  = ch_st[g].ovr;
        end
    endgenerate

    // read mux; channel words are read only, writes to them are dropped
    always_comb begin
        rd_word = 32'h0;
        rd_err  = 1'b0;
        if (chan_hit) begin
            rd_word = word[idx];
        end else if (stat_hit) begin
            rd_word = {7'h00, stat_r};
        end else if (mask_hit) begin
            rd_word = {7'h00, mask_r};
        end else begin
            rd_err = 1'b1;
        end
    end

    // data sampled in setup so the access phase needs no wait
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_r <= 32'h0;
            err_r    <= 1'b0;
        end else if (setup) begin
            prdata_r <= pwrite_in ? 32'h0 : rd_word;
            err_r    <= rd_err;
        end
    end

    assign prdata_out  = prdata_r;
    assign pready_out  = 1'b1;
    assign pslverr_out = access && err_r;

    // mask register
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_r <= `ACRT_MASK_RST;
        end else if (access && pwrite_in && mask_hit) begin
            mask_r <= pwdata_in[`ACRT_STAT_W-1:0];
        end
    end

    // sticky status, cleared by its read; a new event wins
    always_comb begin
        stat_nxt = stat_clr ? `ACRT_STAT_RST : stat_r;
        stat_nxt[NCH-1:0] = stat_nxt[NCH-1:0] | load;
        stat_nxt[`ACRT_STAT_CMP_LSB +: NCH] = stat_nxt[`ACRT_STAT_CMP_LSB +: NCH] | cmp_evt;
        stat_nxt[`ACRT_STAT_OVR_BIT] = stat_nxt[`ACRT_STAT_OVR_BIT] | (|ovr_evt);
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stat_r <= `ACRT_STAT_RST;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign irq_out         = |(stat_r & mask_r);
    // any channel's overrun flag raises the level request while mask bit 24 is set
    assign overrun_req_out = (|ovr_flags_out) && mask_r[`ACRT_STAT_OVR_BIT];

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    // status and mask words use bits 24:20, so only channel reads are held to zero
    reserved_zero_a: assert property (
        (|rd_clr) |=> (prdata_out[25:20] == 6'h00) && (prdata_out[3:0] == 4'h0))
        else $error("reserved read bits not zero");

    stat_clear_a: assert property (
        stat_clr && !(|load) && !(|cmp_evt) && !(|ovr_evt) |=> stat_r == '0)
        else $error("status not cleared by read");

    bad_addr_a: assert property (
        access && !chan_hit && !stat_hit && !mask_hit |-> pslverr_out)
        else $error("unmapped access not flagged");

    mask_write_a: assert property (
        access && pwrite_in && mask_hit |=> mask_r == $past(pwdata_in[`ACRT_STAT_W-1:0]))
        else $error("mask write lost");

    zero_wait_a: assert property (
        access |-> pready_out)
        else $error("access phase stretched");

    generate
        for (g = 0; g < NCH; g++) begin : gen_chk
            result_load_a: assert property (
                load[g] |=> ch_st[g].result == $past(conv_in.result))
                else $error("result not loaded");

            fullscale_a: assert property (
                load[g] && (conv_in.result == 12'hfff) |=>
                ch_st[g].result == 12'hfff && ch_st[g].rng != `ACRT_RANGE_BELOW
                || $past(sel_thr[g].low) == 12'hfff)
                else $error("full scale result lost");

            range_in_a: assert property (
                load[g] && (conv_in.result >= sel_thr[g].low) &&
                (conv_in.result <= sel_thr[g].high) |=>
                ch_st[g].rng == `ACRT_RANGE_IN)
                else $error("in range code wrong");

            range_below_a: assert property (
                load[g] && (conv_in.result < sel_thr[g].low) |=>
                ch_st[g].rng == `ACRT_RANGE_BELOW)
                else $error("below range code wrong");

            range_above_a: assert property (
                load[g] && (conv_in.result >= sel_thr[g].low) &&
                (conv_in.result > sel_thr[g].high) |=>
                ch_st[g].rng == `ACRT_RANGE_ABOVE)
                else $error("above range code wrong");

            codes_legal_a: assert property (
                (ch_st[g].rng != 2'h3) && (ch_st[g].crs != 2'h1))
                else $error("reserved compare code produced");

            cross_none_a: assert property (
                load[g] && ((ch_st[g].result < sel_thr[g].low) ==
                (conv_in.result < sel_thr[g].low)) |=>
                ch_st[g].crs == `ACRT_CROSS_NONE)
                else $error("crossing reported on same side");

            cross_down_a: assert property (
                load[g] && ch_st[g].seen && (ch_st[g].result >= sel_thr[g].low) &&
                (conv_in.result < sel_thr[g].low) |=>
                ch_st[g].crs == `ACRT_CROSS_DOWN)
                else $error("downward crossing missed");

            cross_up_a: assert property (
                load[g] && ch_st[g].seen && (ch_st[g].result < sel_thr[g].low) &&
                (conv_in.result >= sel_thr[g].low) |=>
                ch_st[g].crs == `ACRT_CROSS_UP)
                else $error("upward crossing missed");

            chan_field_a: assert property (
                rd_clr[g] |=> prdata_out[29:26] == 4'(g) && pslverr_out == 1'b0)
                else $error("channel number field wrong");

            done_set_a: assert property (
                load[g] |=> ch_st[g].done && stat_r[g])
                else $error("completion flag not set");

            done_clear_a: assert property (
                clr[g] && !load[g] |=> !ch_st[g].done && !ch_st[g].ovr)
                else $error("flags not cleared by read");

            ovr_set_a: assert property (
                load[g] && ch_st[g].done && !clr[g] |=>
                ch_st[g].ovr && stat_r[`ACRT_STAT_OVR_BIT])
                else $error("overrun not flagged");

            thr_set_a: assert property (
                load[g] && thr_sel_in[g] && (conv_in.result < thr1_in.low) |=>
                ch_st[g].rng == `ACRT_RANGE_BELOW)
                else $error("threshold set 1 not used");

            hold_a: assert property (
                !load[g] |=> $stable(ch_st[g].result) && $stable(ch_st[g].crs) &&
                $stable(ch_st[g].rng))
                else $error("result changed without conversion");

            clear_wins_a: assert property (
                load[g] && clr[g] |=> ch_st[g].done && !ch_st[g].ovr)
                else $error("read with conversion counted as overrun");

            cmp_status_a: assert property (
                load[g] && (conv_in.result < sel_thr[g].low) |=>
                stat_r[`ACRT_STAT_CMP_LSB + g])
                else $error("compare event not in status");

            read_data_a: assert property (
                rd_clr[g] |=> prdata_out[15:4] == $past(ch_st[g].result))
                else $error("read data not the stored result");
        end
    endgenerate

    cross_up_c: cover property (
        load[0] ##1 ch_st[0].crs == `ACRT_CROSS_UP);
    cross_down_c: cover property (
        load[0] ##1 ch_st[0].crs == `ACRT_CROSS_DOWN);
    overrun_c: cover property (
        overrun_req_out ##1 rd_clr[0]);
    irq_c: cover property (
        !irq_out ##1 irq_out ##[1:20] stat_clr);
    gread_clr_c: cover property (
        gread_in.valid ##1 !done_flags_out[7]);

endmodule // acrt_top

// file: acrt_top_tb.sv
// self-checking testbench of the channel result and threshold block
`timescale 1ns/1ps
`include "acrt_params.svh"

module acrt_top_tb;
    import acrt_pkg::*;

    localparam logic [31:0] STAT = `ACRT_STAT_ADDR;
    localparam logic [31:0] MASK = `ACRT_MASK_ADDR;

    logic                 mclk_in = 1'b0;
    logic                 arst_n_in = 1'b0;
    logic                 psel, penable, pwrite;
    logic [31:0]          paddr, pwdata, prdata_out;
    logic                 pready_out, pslverr_out, overrun_req_out, irq_out;
    acrt_conv_type        conv;
    acrt_gread_type       gread;
    acrt_thr_type         thr0, thr1;
    logic [11:0]          thr_sel, done_flags_out, ovr_flags_out;
    logic [1:0]           exp_rng [12];
    logic [1:0]           exp_crs [12];
    logic [11:0]          exp_res [12];
    logic                 seen [12];
    logic                 above [12];
    int                   bad_count = 0;
    int                   checked = 0;

    always #2 mclk_in = ~mclk_in;

    acrt_top dut (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .conv_in(conv), .gread_in(gread), .thr0_in(thr0), .thr1_in(thr1),
        .thr_sel_in(thr_sel), .done_flags_out(done_flags_out),
        .ovr_flags_out(ovr_flags_out), .overrun_req_out(overrun_req_out),
        .irq_out(irq_out)
    );

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    // request held from setup until pready is seen high at an edge
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge mclk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (pready_out !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
        q = prdata_out;
        e = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b1, d, q, e);
        // the write lands at this edge; let it settle before callers look
        #1;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b0, 32'h0, q, e);
        chk(q, x);
        chk(32'(e), 32'(xe));
    endtask

    function automatic logic [31:0] word(input int g, input logic dn, input logic ov);
        return {dn, ov, 4'(g), 6'h00, exp_crs[g], exp_rng[g], exp_res[g], 4'h0};
    endfunction

    function automatic logic [31:0] chan_addr(input int g);
        return `ACRT_CHAN_BASE + 32'(4 * g);
    endfunction

    // model keeps range and crossing expectations; "above" means at or over low
    task automatic conv_pulse(input int g, input logic [11:0] v);
        acrt_thr_type t;
        logic         ab;
        // expectation taken after the edge so a select changed just before counts
        @(posedge mclk_in);
        if (g < 12) begin
            t = thr_sel[g] ? thr1 : thr0;
            ab = (v >= t.low);
            exp_rng[g] = (v < t.low) ? 2'h1 : ((v > t.high) ? 2'h2 : 2'h0);
            exp_crs[g] = (!seen[g] || ab == above[g]) ? 2'h0 : (ab ? 2'h3 : 2'h2);
            seen[g] = 1'b1;
            above[g] = ab;
            exp_res[g] = v;
        end
        conv <= '{valid: 1'b1, chan: 4'(g), result: v};
        @(posedge mclk_in);
        conv <= '0;
        #1;
    endtask

    task automatic gread_pulse(input int g);
        @(posedge mclk_in);
        gread <= '{valid: 1'b1, chan: 4'(g)};
        @(posedge mclk_in);
        gread <= '0;
        #1;
    endtask

    logic [11:0] vals3 [8] = '{12'h050, 12'h400, 12'h900, 12'h0ff,
                               12'h100, 12'h800, 12'hfff, 12'h000};
    logic [11:0] vals5 [4] = '{12'h150, 12'h250, 12'h350, 12'h1ff};
    logic [31:0] q;
    logic        e;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        conv = '0;
        gread = '0;
        thr0 = '{low: 12'h100, high: 12'h800};
        thr1 = '{low: 12'h200, high: 12'h300};
        thr_sel = 12'h000;
        for (int g = 0; g < 12; g++) begin
            exp_rng[g] = 2'h0;
            exp_crs[g] = 2'h0;
            exp_res[g] = 12'h000;
            seen[g] = 1'b0;
            above[g] = 1'b0;
        end
        repeat (16) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        chk(32'({irq_out, overrun_req_out, done_flags_out, ovr_flags_out}), 32'h0);
        for (int g = 0; g < 12; g++) begin
            rdchk(chan_addr(g), word(g, 1'b0, 1'b0), 1'b0);
        end
        // channel numbers past the last one must not touch any flag
        conv_pulse(12, 12'habc);
        chk(32'(done_flags_out), 32'h0);
        for (int i = 0; i < 8; i++) begin
            conv_pulse(3, vals3[i]);
            rdchk(chan_addr(3), word(3, 1'b1, 1'b0), 1'b0);
        end
        rdchk(chan_addr(3), word(3, 1'b0, 1'b0), 1'b0);
        wr(chan_addr(3), 32'hc00ffff0);
        rdchk(chan_addr(3), word(3, 1'b0, 1'b0), 1'b0);
        thr_sel <= 12'h020;
        for (int i = 0; i < 4; i++) begin
            conv_pulse(5, vals5[i]);
            rdchk(chan_addr(5), word(5, 1'b1, 1'b0), 1'b0);
        end
        rdchk(32'h4001c108, 32'h0, 1'b1);
        rdchk(chan_addr(12), 32'h0, 1'b1);
        // interrupt: status sticky, masked, cleared by read
        apb(STAT, 1'b0, 32'h0, q, e);
        wr(MASK, 32'h0);
        conv_pulse(9, 12'h400);
        chk(32'(irq_out), 32'h0);
        wr(MASK, 32'h0000_0200);
        chk(32'(irq_out), 32'h1);
        rdchk(STAT, 32'h0000_0200, 1'b0);
        chk(32'(irq_out), 32'h0);
        conv_pulse(9, 12'h050);
        // channel 9 was overwritten unread, so its overrun is flagged too
        rdchk(STAT, 32'h0120_0200, 1'b0);
        // overrun: second completion before the first is read
        conv_pulse(7, 12'h300);
        conv_pulse(7, 12'h310);
        chk(32'(ovr_flags_out), 32'h0000_0280);
        chk(32'(overrun_req_out), 32'h0);
        wr(MASK, 32'h0100_0000);
        chk(32'(overrun_req_out), 32'h1);
        chk(32'(irq_out), 32'h1);
        rdchk(chan_addr(7), word(7, 1'b1, 1'b1), 1'b0);
        chk(32'({overrun_req_out, ovr_flags_out}), 32'h0000_1200);
        // a read through the global result register also clears the flag
        conv_pulse(7, 12'h123);
        chk(32'(done_flags_out[7]), 32'h1);
        gread_pulse(7);
        chk(32'(done_flags_out[7]), 32'h0);
        chk(32'(done_flags_out[9]), 32'h1);
        // a conversion landing with a read is not an overrun
        conv_pulse(7, 12'h124);
        @(posedge mclk_in);
        conv <= '{valid: 1'b1, chan: 4'h7, result: 12'h125};
        gread <= '{valid: 1'b1, chan: 4'h7};
        @(posedge mclk_in);
        conv <= '0;
        gread <= '0;
        #1;
        chk(32'({done_flags_out[7], ovr_flags_out[7]}), 32'h2);
        end_of_test();
    end
endmodule // acrt_top_tb
